// ===== flash_core_model.sv
// Flash core stand-in: holds the protect bits and answers a full erase
`timescale 1ns/100ps
module flash_core_model
  import flash_protect_pkg::*;
(
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset,
  input  wire flash_protect_pkg::flash_cmd_t i_cmd,
  input  wire logic                          i_cmd_valid,
  input  wire logic                          i_load,
  input  wire logic [3:0]                    i_load_bits,
  output logic                               o_ready,
  output logic                               o_cleared,
  output logic      [3:0]                    o_bits
);
  logic [2:0] busy_reg;
  // Protect bits are nonvolatile, so reset leaves them alone
  always_ff @(posedge i_sys_clk) begin
    if (i_load) begin
      o_bits <= i_load_bits;
    end else if (busy_reg == 3'h1) begin
      o_bits <= 4'h0;
    end
  end
  // Erase takes a few cycles so the filter has to wait for it
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_reg  <= 3'h0;
      o_cleared <= 1'b0;
    end else if (i_cmd_valid && i_cmd == CMD_CHIP_ALL) begin
      busy_reg  <= 3'h4;
      o_cleared <= 1'b0;
    end else if (busy_reg != 3'h0) begin
      busy_reg  <= busy_reg - 3'h1;
      o_cleared <= (busy_reg == 3'h1);
    end
  end
  assign o_ready = (busy_reg == 3'h0);
endmodule

// ===== flash_protect_pkg.sv
// Package: constants and carriers for the flash/ROM/debug protection block
package flash_protect_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [11:0] ADDR_FLASH_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_ROM_CTRL      = 12'h004;
  localparam logic [11:0] ADDR_ROM_CTRL2     = 12'h008;
  localparam logic [11:0] ADDR_DEBUG_MODE    = 12'h00C;
  localparam logic [11:0] ADDR_PROTECT_STAT  = 12'h010;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          NUM_BLOCKS         = 4;
  localparam int          FLS_READY_BIT      = 0;
  localparam int          FLS_ROMTYPE_BIT    = 2;
  localparam int          FLS_PROT_LSB       = 4;
  localparam int          ROM_CTRL_EN_BIT    = 0;
  localparam int          DBG_DISABLE_BIT    = 0;
  localparam logic        DBG_DISABLE_RST    = 1'b1;
  localparam logic        ROM_EN_RST         = 1'b0;
  localparam logic [7:0]  ROM_CTRL2_RST      = 8'h00;

  // ****************************************************************
  // Address map of the protected array
  // ****************************************************************
  localparam logic [31:0] ROM_BASE           = 32'hBFC0_0000;
  localparam logic [31:0] ROM_LIMIT          = 32'hBFC7_FFFF;
  localparam logic [31:0] ROM_PEEK_ADDR0     = 32'hBFC0_0000;
  localparam logic [31:0] ROM_PEEK_ADDR1     = 32'hBFC0_0002;
  localparam int          BLOCK_BYTES        = 131072;

  // Erase commands presented to the flash core
  typedef enum logic [1:0] {
    CMD_NONE       = 2'b00,
    CMD_PROT_ERASE = 2'b01,
    CMD_OTHER      = 2'b10,
    CMD_CHIP_ALL   = 2'b11
  } flash_cmd_t;

  // One access request from a bus master
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic        from_rom;   // Issuing instruction fetched from ROM
    logic        patched;    // Instruction patched into RAM by ROM correction
  } access_req_t;

endpackage

// ===== flash_rom_debug_protect.sv
// Flash/ROM read protection, block write protection and debug-unit disconnect
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps

module flash_rom_debug_protect
  import flash_protect_pkg::*;
#(
  parameter bit IS_MASK_ROM = 1'b0
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset,
  // APB slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [11:0]                   i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  input  wire flash_protect_pkg::access_req_t i_apb_src,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // Nonvolatile protect bits and flash core status
  input  wire logic [3:0]                    i_block_protect_bits,
  input  wire logic                          i_flash_ready,
  input  wire logic                          i_prot_bits_cleared,
  // Processor data access
  input  wire flash_protect_pkg::access_req_t i_cpu_req,
  output logic                               o_cpu_allow,
  // DMA: register write and data transfer
  input  wire flash_protect_pkg::access_req_t i_dma_reg_req,
  output logic                               o_dma_reg_allow,
  output logic                               o_bus_error_nmi,
  input  wire logic                          i_dma_xfer_valid,
  output logic                               o_dma_xfer_allow,
  // Debug port
  input  wire flash_protect_pkg::access_req_t i_dbg_req,
  output logic                               o_dbg_allow,
  output logic                               o_debug_unit_off,
  // Flash command path
  input  wire logic                          i_writer_mode,
  input  wire logic                          i_cmd_valid,
  input  wire flash_protect_pkg::flash_cmd_t i_cmd,
  input  wire logic                          i_cmd_unprotect_seq,
  input  wire logic [31:0]                   i_cmd_addr,
  output flash_protect_pkg::flash_cmd_t      o_cmd,
  output logic                               o_cmd_valid,
  output logic      [31:0]                   o_cmd_addr,
  output logic      [3:0]                    o_block_wr_protect,
  output logic                               o_global_protect,
  output logic                               o_rom_protect
);
  import flash_protect_pkg::*;

  // ****************************************************************
  // Protection state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_ERASE    = 2'b01,
    ST_CLR_BITS = 2'b10
  } release_state_t;

  logic           rom_en_reg;
  logic [7:0]     rom_ctrl2_reg;
  logic           debug_disable_reg;
  release_state_t rel_state_reg;
  logic           global_prot;
  logic           rom_prot;
  logic           dbg_prot;

  assign global_prot = IS_MASK_ROM ? 1'b1 : (&i_block_protect_bits);
  assign rom_prot    = rom_en_reg & global_prot;
  assign dbg_prot    = debug_disable_reg & global_prot;

  assign o_global_protect = global_prot;
  assign o_rom_protect    = rom_prot;
  assign o_debug_unit_off = dbg_prot;

  // Each block refuses program/erase while its bit is set
  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++) begin : g_blk
      assign o_block_wr_protect[g] = IS_MASK_ROM | i_block_protect_bits[g];
    end
  endgenerate

  // ****************************************************************
  // Address classification
  // ****************************************************************
  function automatic logic in_rom(input logic [31:0] a);
    in_rom = (a >= ROM_BASE) && (a <= ROM_LIMIT);
  endfunction

  // Patched instructions show a ROM PC but really run from RAM
  function automatic logic trusted(input access_req_t r);
    trusted = r.from_rom & ~r.patched;
  endfunction

  logic cpu_rom_data;
  logic cpu_peek_ok;
  assign cpu_rom_data = in_rom(i_cpu_req.addr);
  assign cpu_peek_ok  = ~i_cpu_req.write &
                        ((i_cpu_req.addr == ROM_PEEK_ADDR0) |
                         (i_cpu_req.addr == ROM_PEEK_ADDR1));

  // Non-ROM data and trusted ROM code stay open
  assign o_cpu_allow = ~rom_prot | ~cpu_rom_data | trusted(i_cpu_req)
                       | cpu_peek_ok;

  assign o_dbg_allow = ~(rom_prot & in_rom(i_dbg_req.addr));

  assign o_dma_xfer_allow = i_dma_xfer_valid;

  assign o_dma_reg_allow = ~rom_prot | trusted(i_dma_reg_req);

  // ****************************************************************
  // Bus error pulse for refused DMA register writes
  // ****************************************************************
  logic nmi_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nmi_reg <= 1'b0;
    end else begin
      nmi_reg <= i_dma_reg_req.valid & i_dma_reg_req.write & ~o_dma_reg_allow;
    end
  end
  assign o_bus_error_nmi = nmi_reg;

  // ****************************************************************
  // Flash command filter
  // ****************************************************************
  always_comb begin
    o_cmd       = i_cmd;
    o_cmd_valid = i_cmd_valid;
    o_cmd_addr  = i_cmd_addr;
    if (rel_state_reg == ST_ERASE) begin
      o_cmd       = CMD_CHIP_ALL;
      o_cmd_valid = 1'b1;
    end else if (rom_prot) begin
      if (i_writer_mode) begin
        o_cmd_valid = i_cmd_valid & i_cmd_unprotect_seq;
      end else begin
        o_cmd_valid = 1'b0;
        o_cmd_addr  = 32'h0000_0000;
      end
    end else if (global_prot && !IS_MASK_ROM) begin
      if (i_cmd == CMD_PROT_ERASE) begin
        o_cmd_valid = 1'b0;
      end else begin
        o_cmd_valid = 1'b0;
      end
    end else if (IS_MASK_ROM) begin
      o_cmd_valid = 1'b0;
    end
  end

  // Release: full erase first, then wait for all protect bits to clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rel_state_reg <= ST_IDLE;
    end else begin
      case (rel_state_reg)
        ST_IDLE: begin
          if (global_prot && !rom_prot && !IS_MASK_ROM && i_cmd_valid
              && i_cmd == CMD_PROT_ERASE) begin
            rel_state_reg <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          rel_state_reg <= ST_CLR_BITS;
        end
        ST_CLR_BITS: begin
          if (i_flash_ready && i_prot_bits_cleared) begin
            rel_state_reg <= ST_IDLE;
          end
        end
        default: begin
          rel_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  logic apb_wr;
  logic wr_ok;
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign wr_ok     = ~rom_prot | trusted(i_apb_src);
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rom_en_reg    <= ROM_EN_RST;
      rom_ctrl2_reg <= ROM_CTRL2_RST;
    end else if (apb_wr && wr_ok) begin
      if (i_paddr == ADDR_ROM_CTRL) begin
        rom_en_reg <= i_pwdata[ROM_CTRL_EN_BIT];
      end
      if (i_paddr == ADDR_ROM_CTRL2) begin
        rom_ctrl2_reg <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      debug_disable_reg <= DBG_DISABLE_RST;
    end else if (apb_wr && wr_ok && i_paddr == ADDR_DEBUG_MODE) begin
      debug_disable_reg <= i_pwdata[DBG_DISABLE_BIT];
    end
  end

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      ADDR_FLASH_STATUS: begin
        rdata[FLS_PROT_LSB +: NUM_BLOCKS] = i_block_protect_bits;
        rdata[FLS_ROMTYPE_BIT]            = IS_MASK_ROM;
        rdata[FLS_READY_BIT]              = IS_MASK_ROM | i_flash_ready;
      end
      ADDR_ROM_CTRL:     rdata[ROM_CTRL_EN_BIT] = rom_en_reg;
      ADDR_ROM_CTRL2:    rdata[7:0] = rom_ctrl2_reg;
      ADDR_DEBUG_MODE:   rdata[DBG_DISABLE_BIT] = debug_disable_reg;
      ADDR_PROTECT_STAT: rdata[2:0] = {dbg_prot, rom_prot, global_prot};
      default:           rdata = 32'h0000_0000;
    endcase
  end

  assign o_prdata = rdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_rom_prot_def: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rom_prot == (rom_en_reg & global_prot))
    else $error("rom protect mismatch");
  chk_dbg_prot_def: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_debug_unit_off == (debug_disable_reg & global_prot))
    else $error("debug protect mismatch");
  chk_global_and: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !IS_MASK_ROM |-> (o_global_protect == &i_block_protect_bits))
    else $error("global protect not AND");
  chk_cpu_block_rom: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && in_rom(i_cpu_req.addr) && !i_cpu_req.from_rom && !cpu_peek_ok)
      |-> !o_cpu_allow)
    else $error("ROM data leaked");
  chk_dbg_block: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && in_rom(i_dbg_req.addr)) |-> !o_dbg_allow)
    else $error("debug ROM access leaked");
  chk_dma_nmi: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_dma_reg_req.valid && i_dma_reg_req.write && !o_dma_reg_allow) |=> o_bus_error_nmi)
    else $error("missing bus error");
  chk_cmd_masked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && !i_writer_mode && rel_state_reg == ST_IDLE) |-> !o_cmd_valid)
    else $error("command passed under protection");
  chk_reg_masked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (apb_wr && rom_prot && !trusted(i_apb_src)) |=> $stable(rom_en_reg))
    else $error("protect register overwritten");
  chk_release_erase: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rel_state_reg == ST_ERASE) |-> (o_cmd == CMD_CHIP_ALL && o_cmd_valid)
      ##1 (rel_state_reg == ST_CLR_BITS))
    else $error("release erase missing");

  // Further checks on register masking, DMA, access paths and the protected command filter branches
  chk_no_global_open: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !o_global_protect
      |-> (!o_rom_protect && !o_debug_unit_off))
    else $error("protection active without global protect");
  chk_dbg_reg_masked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (apb_wr && rom_prot && !trusted(i_apb_src))
      |=> $stable(debug_disable_reg))
    else $error("debug disable overwritten");
  chk_ctrl2_masked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (apb_wr && rom_prot && !trusted(i_apb_src))
      |=> $stable(rom_ctrl2_reg))
    else $error("second protect register overwritten");
  chk_dma_xfer_open: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && i_dma_xfer_valid)
      |-> o_dma_xfer_allow)
    else $error("DMA transfer refused");
  chk_dma_reg_trust: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_dma_reg_req.valid && trusted(i_dma_reg_req))
      |-> o_dma_reg_allow)
    else $error("trusted DMA register write refused");
  chk_writer_filter: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && i_writer_mode && rel_state_reg == ST_IDLE && !i_cmd_unprotect_seq)
      |-> !o_cmd_valid)
    else $error("writer command passed under protection");
  chk_cmd_addr_mask: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && !i_writer_mode && rel_state_reg == ST_IDLE)
      |-> (o_cmd_addr == 32'h0000_0000))
    else $error("command address not masked");
  chk_other_cmd_drop: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (global_prot && !rom_prot && rel_state_reg == ST_IDLE)
      |-> !o_cmd_valid)
    else $error("command passed under global protect");
  chk_release_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rel_state_reg == ST_IDLE && global_prot && !rom_prot && !IS_MASK_ROM && i_cmd_valid
     && i_cmd == CMD_PROT_ERASE) |=> (rel_state_reg == ST_ERASE))
    else $error("protect erase not converted");
  chk_release_wait: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rel_state_reg == ST_CLR_BITS && !(i_flash_ready && i_prot_bits_cleared))
      |=> (rel_state_reg == ST_CLR_BITS))
    else $error("release left before bits cleared");
  chk_trusted_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!in_rom(i_cpu_req.addr) || trusted(i_cpu_req))
      |-> o_cpu_allow)
    else $error("permitted access refused");
  chk_patched_deny: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rom_prot && in_rom(i_cpu_req.addr) && i_cpu_req.patched && !cpu_peek_ok)
      |-> !o_cpu_allow)
    else $error("patched code read ROM data");
  chk_peek_open: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    cpu_peek_ok
      |-> o_cpu_allow)
    else $error("peek address refused");
  chk_status_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_paddr == ADDR_FLASH_STATUS)
      |-> (o_prdata[FLS_PROT_LSB +: NUM_BLOCKS] == i_block_protect_bits))
    else $error("status protect bits wrong");
  chk_blk_wr_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !IS_MASK_ROM
      |-> (o_block_wr_protect == i_block_protect_bits))
    else $error("block write protect wrong");
  chk_dbg_port_open: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !rom_prot
      |-> o_dbg_allow)
    else $error("debug access refused without protection");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  cov_rom_prot: cover property (@(posedge i_sys_clk) disable iff (i_reset) rom_prot);
  cov_release: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    rel_state_reg == ST_ERASE);
  cov_nmi: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_bus_error_nmi);
  cov_peek: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    rom_prot && cpu_peek_ok && !i_cpu_req.from_rom);
  cov_writer_seq: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    rom_prot && i_writer_mode && o_cmd_valid);

endmodule

// ===== testbench.sv
// Self-checking bench for the flash/ROM/debug protection block
`timescale 1ns/100ps
module testbench;
  import flash_protect_pkg::*;
  logic i_sys_clk, i_reset, i_psel, i_penable, i_pwrite, i_dma_xfer_valid;
  logic i_writer_mode, i_cmd_valid, i_cmd_unprotect_seq, ld, rdy, clr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, i_cmd_addr, q;
  logic [3:0] ld_bits, bits;
  access_req_t i_apb_src, i_cpu_req, i_dma_reg_req, i_dbg_req;
  flash_cmd_t i_cmd;
  wire logic [31:0] o_prdata, o_cmd_addr;
  wire logic [3:0] o_block_wr_protect;
  wire logic o_pready, o_cpu_allow, o_dma_reg_allow, o_bus_error_nmi, o_dma_xfer_allow;
  wire logic o_dbg_allow, o_debug_unit_off, o_cmd_valid, o_global_protect, o_rom_protect;
  wire logic o_pslverr;
  flash_cmd_t o_cmd;
  int n_mismatch, samples_checked, n;
  flash_rom_debug_protect flash_rom_debug_protect_i (.i_sys_clk, .i_reset, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_apb_src, .o_prdata, .o_pready,
    .o_pslverr, .i_block_protect_bits(bits), .i_flash_ready(rdy),
    .i_prot_bits_cleared(clr), .i_cpu_req, .o_cpu_allow, .i_dma_reg_req, .o_dma_reg_allow,
    .o_bus_error_nmi, .i_dma_xfer_valid, .o_dma_xfer_allow, .i_dbg_req, .o_dbg_allow,
    .o_debug_unit_off, .i_writer_mode, .i_cmd_valid, .i_cmd, .i_cmd_unprotect_seq,
    .i_cmd_addr, .o_cmd, .o_cmd_valid, .o_cmd_addr, .o_block_wr_protect,
    .o_global_protect, .o_rom_protect);
  flash_core_model flash_core_model_i (.i_sys_clk, .i_reset, .i_cmd(o_cmd),
    .i_cmd_valid(o_cmd_valid), .i_load(ld), .i_load_bits(ld_bits), .o_ready(rdy),
    .o_cleared(clr), .o_bits(bits));
  always #10 i_sys_clk = ~i_sys_clk;
  function automatic access_req_t mk(input logic [31:0] a, input logic w, r, p);
    mk = '{1'b1, w, a, r, p};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; rom says where the issuing code lives
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic rom);
    int k;
    @(posedge i_sys_clk);
    i_psel    <= 1'b1;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    i_apb_src <= mk(32'h0, wr, rom, 1'b0);
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    q = o_prdata;
    check(o_pslverr, 1'b0);
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic load(input logic [3:0] b);
    @(posedge i_sys_clk);
    ld      <= 1'b1;
    ld_bits <= b;
    @(posedge i_sys_clk);
    ld <= 1'b0;
    #1;
  endtask
  task automatic acc(input logic [31:0] a, input logic r, p, ecpu, edbg);
    @(posedge i_sys_clk);
    i_cpu_req <= mk(a, 1'b0, r, p);
    i_dbg_req <= mk(a, 1'b0, 1'b0, 1'b0);
    #1;
    check(o_cpu_allow, ecpu);
    check(o_dbg_allow, edbg);
  endtask
  task automatic cmd(input flash_cmd_t c, input logic w, u);
    @(posedge i_sys_clk);
    i_cmd_valid         <= 1'b1;
    i_cmd               <= c;
    i_writer_mode       <= w;
    i_cmd_unprotect_seq <= u;
    #1;
  endtask
  initial begin
    {i_sys_clk, i_psel, i_penable, i_pwrite, i_dma_xfer_valid} = '0;
    {i_writer_mode, i_cmd_valid, i_cmd_unprotect_seq, i_paddr, i_pwdata} = '0;
    {i_apb_src, i_cpu_req, i_dma_reg_req, i_dbg_req} = '0;
    i_cmd      = CMD_NONE;
    i_cmd_addr = ROM_BASE;
    ld_bits    = 4'hF;
    // Protect bits must be defined before the checks wake up
    ld         = 1'b1;
    i_reset    = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    ld      <= 1'b0;
    load(4'hF);
    apb(1'b0, ADDR_DEBUG_MODE, 32'h0, 1'b0); check(q, 32'h1);
    check(o_global_protect, 1'b1);
    check(o_debug_unit_off, 1'b1);
    check(o_rom_protect, 1'b0);
    // ************************************************
    // Global protect release by protect-bit erase
    // ************************************************
    cmd(CMD_OTHER, 1'b0, 1'b0); check(o_cmd_valid, 1'b0);
    cmd(CMD_PROT_ERASE, 1'b0, 1'b0); check(o_cmd_valid, 1'b0);
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    #1;
    check({o_cmd_valid, o_cmd}, {1'b1, CMD_CHIP_ALL});
    for (n = 0; n < 30 && (bits !== 4'h0 || rdy !== 1'b1); n++) @(posedge i_sys_clk);
    if (n == 30) begin
      n_mismatch++;
      conclude();
    end
    #1;
    check(o_global_protect, 1'b0);
    check(o_debug_unit_off, 1'b0);
    load(4'h5);
    apb(1'b0, ADDR_FLASH_STATUS, 32'h0, 1'b0); check(q, 32'h51);
    check(o_block_wr_protect, 4'h5);
    // Enable is accepted from any code while global protect is off
    apb(1'b1, ADDR_ROM_CTRL, 32'h1, 1'b0); check(o_rom_protect, 1'b0);
    load(4'hF);
    check(o_rom_protect, 1'b1);
    // ************************************************
    // Access filtering under ROM protection
    // ************************************************
    acc(ROM_BASE + 32'h100, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(ROM_BASE + 32'h100, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(ROM_BASE + 32'h100, 1'b1, 1'b1, 1'b0, 1'b0);
    acc(ROM_PEEK_ADDR1, 1'b0, 1'b0, 1'b1, 1'b0);
    acc(32'hA000_0000, 1'b0, 1'b0, 1'b1, 1'b1);
    @(posedge i_sys_clk);
    i_dma_reg_req    <= mk(32'h0, 1'b1, 1'b0, 1'b0);
    i_dma_xfer_valid <= 1'b1;
    #1;
    check(o_dma_reg_allow, 1'b0);
    check(o_dma_xfer_allow, 1'b1);
    @(posedge i_sys_clk);
    i_dma_reg_req <= '0;
    #1;
    check(o_bus_error_nmi, 1'b1);
    @(posedge i_sys_clk);
    #1;
    check(o_bus_error_nmi, 1'b0);
    apb(1'b1, ADDR_DEBUG_MODE, 32'h0, 1'b0);
    apb(1'b0, ADDR_DEBUG_MODE, 32'h0, 1'b0); check(q, 32'h1);
    apb(1'b1, ADDR_DEBUG_MODE, 32'h0, 1'b1);
    apb(1'b0, ADDR_DEBUG_MODE, 32'h0, 1'b1); check(q, 32'h0);
    check(o_debug_unit_off, 1'b0);
    apb(1'b1, ADDR_ROM_CTRL2, 32'hA5, 1'b0);
    apb(1'b0, ADDR_ROM_CTRL2, 32'h0, 1'b0); check(q, 32'h0);
    apb(1'b1, ADDR_ROM_CTRL2, 32'hA5, 1'b1);
    apb(1'b0, ADDR_ROM_CTRL2, 32'h0, 1'b1); check(q, 32'hA5);
    cmd(CMD_OTHER, 1'b0, 1'b0); check(o_cmd_valid, 1'b0);
    check(o_cmd_addr, 32'h0000_0000);
    cmd(CMD_OTHER, 1'b1, 1'b0); check(o_cmd_valid, 1'b0);
    cmd(CMD_OTHER, 1'b1, 1'b1); check(o_cmd_valid, 1'b1);
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    apb(1'b0, 12'h020, 32'h0, 1'b1); check(q, 32'h0);
    conclude();
  end
endmodule
